// ---- hdl/rtc_irq_map.svh ----
// Register map, field positions, reset values and timing figures of the
// status and interrupt block. Definitions only; include by bare name.
`ifndef RTC_IRQ_MAP_SVH
`define RTC_IRQ_MAP_SVH

`define IRQ_ENABLE_CONTROL_ADDR   4'hE
`define IRQ_FLAG_STATUS_ADDR      4'hF

// Enable/control register
`define EN_WEEKDAY_ALARM_BIT      7
`define EN_DAILY_ALARM_BIT        6
`define EN_CLKOUT_OFF2_BIT        4
`define EN_PERIODIC_SEL_HI        2
`define EN_PERIODIC_SEL_LO        0
`define ENABLE_CONTROL_RESET      8'h00
`define ENABLE_CONTROL_RW_MASK    8'hD7

// Flag/status register
`define FL_SUPPLY_LOW_BIT         6
`define FL_OSC_HALT_BIT           5
`define FL_POWER_UP_BIT           4
`define FL_CLKOUT_OFF1_BIT        3
`define FL_PERIODIC_BIT           2
`define FL_WEEKDAY_ALARM_BIT      1
`define FL_DAILY_ALARM_BIT        0

// Supply sampling window, once per second
`define SAMPLE_WINDOW_US          7800
`define CLK_MHZ                   100
`define SAMPLE_WINDOW_CYCLES      (`SAMPLE_WINDOW_US * `CLK_MHZ)

`endif

// ---- hdl/rtc_irq_pkg.sv ----
// Types shared by the status and interrupt block and its surroundings.
// Assumes the numeric map lives in rtc_irq_map.svh.
package rtc_irq_pkg;

  typedef enum logic [2:0] {
    PER_OFF,
    PER_FIXED_LOW,
    PER_PULSE_2HZ,
    PER_PULSE_1HZ,
    PER_LEVEL_SEC,
    PER_LEVEL_MIN,
    PER_LEVEL_HOUR,
    PER_LEVEL_MONTH
  } periodic_mode_e;

  // Time-base events from the counters, same clock domain
  typedef struct packed {
    logic sec_tick;
    logic min_tick;
    logic hour_tick;
    logic month_tick;
    logic wave_2hz;
    logic wave_1hz;
  } time_events_s;

  // Register access from the two-wire front end
  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// ---- hdl/rtc_irq_status.sv ----
// Status flags, alarm and periodic interrupt logic of the real-time clock.
// Assumes the two-wire front end presents register accesses in this clock
// domain, and that rst_n is the internal power-on reset held until the
// crystal has started.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_map.svh"

module rtc_irq_status #(
  parameter int unsigned TWO_PIN_VARIANT = 1,
  parameter int unsigned SAMPLE_CYCLES   = `SAMPLE_WINDOW_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire rtc_irq_pkg::reg_req_s      reg_req,
  output logic [7:0]                      reg_rdata,
  output logic                            bus_ready,
  input  wire rtc_irq_pkg::time_events_s  time_ev,
  input  wire logic                       weekday_alarm_match,
  input  wire logic                       daily_alarm_match,
  input  wire logic                       osc_running,
  input  wire logic                       supply_at_or_below,
  output logic                            supply_sample_active,
  output logic                            clkout_off1,
  output logic                            clkout_off2,
  output logic                            irq_pin_a_n_o,
  output logic                            irq_pin_a_n_oe,
  output logic                            irq_pin_b_n_o,
  output logic                            irq_pin_b_n_oe
);
  import rtc_irq_pkg::*;

  logic                 weekday_alarm_enable;
  logic                 daily_alarm_enable;
  logic [2:0]           periodic_select;
  logic                 power_up_flag;
  logic                 osc_halt_flag;
  logic                 supply_low_flag;
  logic                 weekday_alarm_flag;
  logic                 daily_alarm_flag;
  logic                 periodic_irq_flag;
  logic                 osc_meta;
  logic                 osc_sync;
  logic                 cmp_meta;
  logic                 cmp_sync;
  logic                 wr_enable_reg;
  logic                 wr_flag_reg;
  logic                 sampling;
  logic [31:0]          sample_count;
  logic                 periodic_event;
  logic                 periodic_level_mode;
  logic                 periodic_pin_req;
  logic                 pin_a_req;
  logic                 pin_b_req;
  periodic_mode_e       periodic_mode;

  // A write of 0 to a flag bit clears it; a 1 leaves it alone
  function automatic logic flag_clear(input logic wr, input logic [7:0] data, input int bit_pos);
    flag_clear = wr && !data[bit_pos];
  endfunction

  // Accesses are only honoured once power-on reset has released
  assign wr_enable_reg = bus_ready && reg_req.wr
                         && (reg_req.addr == `IRQ_ENABLE_CONTROL_ADDR);
  assign wr_flag_reg   = bus_ready && reg_req.wr
                         && (reg_req.addr == `IRQ_FLAG_STATUS_ADDR);

  // Ready rises on the first edge after reset release, so a write taken on that
  // same edge is dropped; the front end waits one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_ready <= 1'b0;
    end else begin
      bus_ready <= 1'b1;
    end
  end

  // Pin-level inputs come from analog circuits outside this clock
  // Both flops reset to 0, so the halt flag stays set for two edges after reset;
  // harmless, since power-on reset sets it anyway
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      osc_meta <= osc_running;
      osc_sync <= osc_meta;
      cmp_meta <= supply_at_or_below;
      cmp_sync <= cmp_meta;
    end
  end

  // Enable/control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      weekday_alarm_enable <= 1'b0;
      daily_alarm_enable   <= 1'b0;
      clkout_off2          <= 1'b0;
      periodic_select      <= 3'h0;
    end else if (wr_enable_reg) begin
      weekday_alarm_enable <= reg_req.wdata[`EN_WEEKDAY_ALARM_BIT];
      daily_alarm_enable   <= reg_req.wdata[`EN_DAILY_ALARM_BIT];
      clkout_off2          <= reg_req.wdata[`EN_CLKOUT_OFF2_BIT];
      periodic_select      <= reg_req.wdata[`EN_PERIODIC_SEL_HI:`EN_PERIODIC_SEL_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkout_off1 <= 1'b0;
    end else if (wr_flag_reg) begin
      clkout_off1 <= reg_req.wdata[`FL_CLKOUT_OFF1_BIT];
    end
  end

  // Power-on reset means the supply came up from zero: all three flags read 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_up_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_POWER_UP_BIT)) begin
      power_up_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_halt_flag <= 1'b1;
    end else if (!osc_sync) begin
      osc_halt_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_OSC_HALT_BIT)) begin
      osc_halt_flag <= 1'b0;
    end
  end

  // Supply sampling: a window opens on each second tick while the flag is 0
  // SAMPLE_CYCLES counts this clock, so it must be rescaled if the clock changes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampling     <= 1'b0;
      sample_count <= 32'h0;
    end else if (supply_low_flag) begin
      sampling     <= 1'b0;
      sample_count <= 32'h0;
    end else if (!sampling && time_ev.sec_tick) begin
      sampling     <= 1'b1;
      sample_count <= 32'h0;
    end else if (sampling) begin
      if (sample_count == SAMPLE_CYCLES - 1) begin
        sampling <= 1'b0;
      end
      sample_count <= sample_count + 32'h1;
    end
  end

  assign supply_sample_active = sampling;

  // While power-up is set, supply-low cannot be cleared: the host clears power-up
  // first and then supply-low, in two writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_low_flag <= 1'b1;
    end else if (power_up_flag) begin
      supply_low_flag <= 1'b1;
    end else if (sampling && cmp_sync) begin
      supply_low_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_SUPPLY_LOW_BIT)) begin
      supply_low_flag <= 1'b0;
    end
  end

  // Alarm flags latch a match while enabled; clearing leaves the enable as is
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      weekday_alarm_flag <= 1'b0;
    end else if (weekday_alarm_enable && weekday_alarm_match) begin
      weekday_alarm_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_WEEKDAY_ALARM_BIT)) begin
      weekday_alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      daily_alarm_flag <= 1'b0;
    end else if (daily_alarm_enable && daily_alarm_match) begin
      daily_alarm_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_DAILY_ALARM_BIT)) begin
      daily_alarm_flag <= 1'b0;
    end
  end

  // Periodic source
  // Every select code is legal, so the decodes below need no default item
  assign periodic_mode       = periodic_mode_e'(periodic_select);
  assign periodic_level_mode = periodic_select[2];

  always_comb begin
    periodic_event = 1'b0;
    unique case (periodic_mode)
      PER_LEVEL_SEC:   periodic_event = time_ev.sec_tick;
      PER_LEVEL_MIN:   periodic_event = time_ev.min_tick;
      PER_LEVEL_HOUR:  periodic_event = time_ev.hour_tick;
      PER_LEVEL_MONTH: periodic_event = time_ev.month_tick;
      PER_OFF, PER_FIXED_LOW, PER_PULSE_2HZ, PER_PULSE_1HZ: periodic_event = 1'b0;
    endcase
  end

  // In level mode the flag is sticky; otherwise it mirrors the live request,
  // since a pulse waveform cannot be acknowledged
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periodic_irq_flag <= 1'b0;
    end else if (!periodic_level_mode) begin
      periodic_irq_flag <= periodic_pin_req;
    end else if (periodic_event) begin
      periodic_irq_flag <= 1'b1;
    end else if (flag_clear(wr_flag_reg, reg_req.wdata, `FL_PERIODIC_BIT)) begin
      periodic_irq_flag <= 1'b0;
    end
  end

  always_comb begin
    periodic_pin_req = 1'b0;
    unique case (periodic_mode)
      PER_OFF:       periodic_pin_req = 1'b0;
      PER_FIXED_LOW: periodic_pin_req = 1'b1;
      PER_PULSE_2HZ: periodic_pin_req = !time_ev.wave_2hz;
      PER_PULSE_1HZ: periodic_pin_req = !time_ev.wave_1hz;
      PER_LEVEL_SEC, PER_LEVEL_MIN, PER_LEVEL_HOUR, PER_LEVEL_MONTH:
        periodic_pin_req = periodic_irq_flag;
    endcase
  end

  // Pin routing: open-drain, only ever driven low
  always_comb begin
    if (TWO_PIN_VARIANT != 0) begin
      pin_a_req = (daily_alarm_flag && daily_alarm_enable) || periodic_pin_req;
      pin_b_req = weekday_alarm_flag && weekday_alarm_enable;
    end else begin
      pin_a_req = (daily_alarm_flag && daily_alarm_enable)
                  || (weekday_alarm_flag && weekday_alarm_enable)
                  || periodic_pin_req;
      pin_b_req = 1'b0;
    end
  end

  // Registered so that a glitch on a combined request never reaches a pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pin_a_n_oe <= 1'b0;
      irq_pin_b_n_oe <= 1'b0;
    end else begin
      irq_pin_a_n_oe <= pin_a_req;
      irq_pin_b_n_oe <= pin_b_req;
    end
  end

  assign irq_pin_a_n_o = 1'b0;
  assign irq_pin_b_n_o = 1'b0;

  // Reading has no side effect; outside level mode the periodic flag follows its request, other flags clear only on an explicit write of 0
  // Read data, one cycle after the address; unmapped addresses read 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.addr == `IRQ_ENABLE_CONTROL_ADDR) begin
      reg_rdata <= {weekday_alarm_enable, daily_alarm_enable, 1'b0, clkout_off2,
                    1'b0, periodic_select};
    end else if (reg_req.addr == `IRQ_FLAG_STATUS_ADDR) begin
      reg_rdata <= {1'b0, supply_low_flag, osc_halt_flag, power_up_flag, clkout_off1,
                    periodic_irq_flag, weekday_alarm_flag, daily_alarm_flag};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- tb/rtc_irq_status_sva.sv ----
// Port-level assertions for the status and interrupt block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_status_sva #(
  parameter int unsigned TWO_PIN_VARIANT = 1,
  parameter int unsigned SAMPLE_CYCLES   = 20
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire rtc_irq_pkg::reg_req_s     reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     bus_ready,
  input wire rtc_irq_pkg::time_events_s time_ev,
  input wire logic                     weekday_alarm_match,
  input wire logic                     supply_sample_active,
  input wire logic                     irq_pin_a_n_oe,
  input wire logic                     irq_pin_b_n_oe
);
  import rtc_irq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int unsigned win_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || !supply_sample_active) win_cnt <= 0;
    else win_cnt <= win_cnt + 1;
  end
  sequence s_fix_low;
    bus_ready && reg_req.wr && reg_req.addr == 4'hE && reg_req.wdata[2:0] == 3'h1;
  endsequence
  sequence s_clr_b;
    bus_ready && reg_req.wr && reg_req.addr == 4'hF && !reg_req.wdata[1] && !weekday_alarm_match;
  endsequence
  property p_ready;
    $rose(rst_n) |-> !bus_ready ##1 bus_ready;
  endproperty
  property p_idle;
    $rose(rst_n) |-> !irq_pin_a_n_oe && !irq_pin_b_n_oe;
  endproperty
  property p_unmapped;
    reg_req.addr < 4'hE |=> reg_rdata == 8'h00;
  endproperty
  property p_fix_low;
    s_fix_low |-> ##2 irq_pin_a_n_oe;
  endproperty
  property p_alarm_b;
    $rose(irq_pin_b_n_oe) |-> TWO_PIN_VARIANT != 0 && $past(weekday_alarm_match, 2);
  endproperty
  property p_clr_b;
    s_clr_b |-> ##2 !irq_pin_b_n_oe;
  endproperty
  property p_win_open;
    $rose(supply_sample_active) |-> $past(time_ev.sec_tick);
  endproperty
  property p_win_len;
    win_cnt <= SAMPLE_CYCLES;
  endproperty
  a_ready: assert property (p_ready) else $error("bus ready timing wrong");
  a_idle: assert property (p_idle) else $error("pin active after reset");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_fix_low: assert property (p_fix_low) else $error("fixed low not driven");
  a_alarm_b: assert property (p_alarm_b) else $error("pin B without match");
  a_clr_b: assert property (p_clr_b) else $error("pin B not released");
  a_win_open: assert property (p_win_open) else $error("window without tick");
  a_win_len: assert property (p_win_len) else $error("window too long");
endmodule
bind rtc_irq_status rtc_irq_status_sva #(
  .TWO_PIN_VARIANT(TWO_PIN_VARIANT),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_sva (
  .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .bus_ready(bus_ready), .time_ev(time_ev), .weekday_alarm_match(weekday_alarm_match),
  .supply_sample_active(supply_sample_active), .irq_pin_a_n_oe(irq_pin_a_n_oe),
  .irq_pin_b_n_oe(irq_pin_b_n_oe)
);
`default_nettype wire

// ---- tb/rtc_irq_pins.sv ----
// Listener model of the open-drain interrupt pins with pull-ups.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_pins (
  input wire logic a_o,
  input wire logic a_oe,
  input wire logic b_o,
  input wire logic b_oe,
  output logic     pin_a_n,
  output logic     pin_b_n
);
  // A released pin goes to the pull-up level, never a held value
  assign pin_a_n = a_oe ? a_o : 1'b1;
  assign pin_b_n = b_oe ? b_o : 1'b1;
endmodule
`default_nettype wire

// ---- tb/rtc_irq_status_tb.sv ----
// Self-checking bench for the status and interrupt block.
// Assumes the checker is bound in and the pin model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_status_tb;
  import rtc_irq_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  reg_req_s     req = '0;
  time_events_s ev = 6'h03;
  logic [1:0]   mt = 2'h0;
  logic         osc = 1'b1;
  logic         low = 1'b0;
  logic [7:0]   rdata;
  logic         rdy, act, ao, aoe, bo, boe, pin_a_n, pin_b_n, co1, co2;
  wire logic [7:0] pinv = {6'h00, pin_b_n, pin_a_n};
  int           failures = 0;
  int           compares = 0;
  int           cycles = 0;
  rtc_irq_status #(.TWO_PIN_VARIANT(1), .SAMPLE_CYCLES(20)) dut (
    .clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .bus_ready(rdy),
    .time_ev(ev), .weekday_alarm_match(mt[1]), .daily_alarm_match(mt[0]),
    .osc_running(osc), .supply_at_or_below(low), .supply_sample_active(act),
    .clkout_off1(co1), .clkout_off2(co2), .irq_pin_a_n_o(ao), .irq_pin_a_n_oe(aoe),
    .irq_pin_b_n_o(bo), .irq_pin_b_n_oe(boe)
  );
  rtc_irq_pins pins (.a_o(ao), .a_oe(aoe), .b_o(bo), .b_oe(boe), .pin_a_n(pin_a_n),
    .pin_b_n(pin_b_n));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, 1'b1, d};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) req.addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [5:0] e, input logic [1:0] m);
    @(posedge clk) begin
      ev <= e | 6'h03;
      mt <= m;
    end
    @(posedge clk) begin
      ev <= 6'h03;
      mt <= 2'h0;
    end
    settle();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, rdy}, 8'h01); // ready
    chk(pinv, 8'h03); // idle
    chk({6'h00, co2, co1}, 8'h00); // clock bits
    rd(4'hF, 8'h70); // flags
    rd(4'hE, 8'h00); // control
    rd(4'h3, 8'h00); // unmapped
    wr(4'hF, 8'h00);
    rd(4'hF, 8'h40); // supply low kept
    wr(4'hF, 8'hF7);
    rd(4'hF, 8'h40); // ones ignored
    wr(4'hF, 8'h00);
    rd(4'hF, 8'h00); // cleared
    @(posedge clk) osc <= 1'b0;
    repeat (6) @(posedge clk);
    osc <= 1'b1;
    rd(4'hF, 8'h20); // halt
    wr(4'hF, 8'h00);
    @(posedge clk) low <= 1'b1;
    pulse(6'h20, 2'h0);
    rd(4'hF, 8'h40); // detect
    pulse(6'h20, 2'h0);
    chk({7'h00, act}, 8'h00); // suspended
    @(posedge clk) low <= 1'b0;
    wr(4'hF, 8'h00);
    pulse(6'h20, 2'h0);
    chk({7'h00, act}, 8'h01); // window
    repeat (16) @(posedge clk);
    #1 chk({7'h00, act}, 8'h01); // last window cycle
    @(posedge clk);
    #1 chk({7'h00, act}, 8'h00); // closed
    rd(4'hF, 8'h00); // no false set
    wr(4'hE, 8'hC0);
    pulse(6'h03, 2'h2);
    chk(pinv, 8'h01); // weekday
    pulse(6'h03, 2'h1);
    chk(pinv, 8'h00); // daily
    rd(4'hF, 8'h03); // flags
    wr(4'hF, 8'hFE);
    settle();
    chk(pinv, 8'h01); // released
    rd(4'hE, 8'hC0); // enables kept
    wr(4'hF, 8'hFC);
    wr(4'hE, 8'h44);
    pulse(6'h23, 2'h1);
    rd(4'hF, 8'h0D); // sources
    wr(4'hF, 8'hFB);
    settle();
    chk(pinv, 8'h02); // still low
    wr(4'hF, 8'hFE);
    settle();
    chk(pinv, 8'h03); // released
    for (int m = 4; m < 8; m++) begin
      wr(4'hE, m[7:0]);
      pulse(6'h20 >> (m - 4), 2'h0);
      chk(pinv, 8'h02); // level
      rd(4'hF, 8'h0C); // flag
      wr(4'hF, 8'hFB);
      settle();
      chk(pinv, 8'h03); // cleared
    end
    wr(4'hE, 8'h01);
    settle();
    chk(pinv, 8'h02); // fixed low
    for (int k = 0; k < 2; k++) begin
      wr(4'hE, 8'h02 + k[7:0]);
      @(posedge clk) ev[1 - k] <= 1'b0;
      settle();
      chk(pinv, 8'h02); // wave low
      @(posedge clk) ev[1 - k] <= 1'b1;
      settle();
      chk(pinv, 8'h03); // wave high
    end
    wr(4'hE, 8'h10);
    rd(4'hE, 8'h10); // clock bit kept
    chk({6'h00, co2, co1}, 8'h03); // clock bits
    wr(4'hE, 8'h00);
    settle();
    chk(pinv, 8'h03); // disabled
    @(posedge clk) rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'hE, 8'h00); // control cleared
    rd(4'hF, 8'h70); // flags set again
    chk(pinv, 8'h03); // idle
    chk({6'h00, co2, co1}, 8'h00); // clock bits cleared
    summarize();
  end
endmodule
`default_nettype wire
